// File: rtl/ibf_pkg.sv
// Package for the I2C bus flag and control block.
// Assumes a 32-bit APB slave port and a byte-wide flag register in lane 0.
package ibf_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] IBF_OFS_FLAG = 8'h00;
	localparam logic [7:0] IBF_OFS_CTRL = 8'h04;
	localparam logic [7:0] IBF_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] IBF_OFS_IRQ_CLR = 8'h0C;
	localparam logic [7:0] IBF_OFS_IRQ_ENA = 8'h10;
	localparam logic [7:0] IBF_OFS_LINE = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int IBF_FLAG_RSV = 0;
	localparam int IBF_FLAG_ISE = 1;
	localparam int IBF_FLAG_BSY = 6;
	localparam int IBF_FLAG_STCF = 7;
	localparam int IBF_CTRL_ENA = 0;
	localparam int IBF_CTRL_STT = 1;
	localparam int IBF_EV_FAIL = 0;
	localparam int IBF_EV_START = 1;
	localparam int IBF_EV_STOP = 2;
	localparam int IBF_LINE_PERMIT = 0;
	localparam int IBF_LINE_SCL = 1;
	localparam int IBF_LINE_SDA = 2;
	localparam int IBF_LINE_PEND = 3;
	localparam int IBF_NUM_EV = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] IBF_FLAG_RESET = 8'h00;
	localparam logic [IBF_NUM_EV-1:0] IBF_EV_RESET = 3'h0;
	localparam logic [31:0] IBF_RDATA_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
		logic start_det;
		logic stop_det;
	} ibf_cond_t;

	typedef struct packed {
		logic scl_m;
		logic sda_m;
		logic scl_s;
		logic sda_s;
		logic scl_d;
		logic sda_d;
		logic start_det;
		logic stop_det;
	} ibf_det_state_t;

	typedef struct packed {
		logic start_fail_flag;
		logic bus_busy_flag;
		logic initial_start_enable;
		logic reservation_disable;
		logic controller_enable;
		logic start_trigger;
		logic start_permit;
		logic start_gen;
		logic [IBF_NUM_EV-1:0] irq_stat;
		logic [IBF_NUM_EV-1:0] irq_ena;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ibf_state_t;

endpackage

// File: rtl/ibf_cond_det.sv
// Start and stop condition detector for the shared I2C lines.
// Assumes scl and sda come straight from pins, asynchronous to pclk.
`timescale 1ns/1ps
module ibf_cond_det
	import ibf_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Detected conditions
	output ibf_cond_t cond
);

	ibf_det_state_t s_ff;
	ibf_det_state_t nxt_s;

	// ------------------------------------------------------------
	// Synchronise the lines and find the conditions
	// ------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.scl_m = scl_in;
		nxt_s.sda_m = sda_in;
		nxt_s.scl_s = s_ff.scl_m;
		nxt_s.sda_s = s_ff.sda_m;
		nxt_s.scl_d = s_ff.scl_s;
		nxt_s.sda_d = s_ff.sda_s;
		// Data falling while the clock stays high marks a start.
		nxt_s.start_det = s_ff.scl_s & s_ff.scl_d & s_ff.sda_d & ~s_ff.sda_s;
		// Data rising while the clock stays high marks a stop.
		nxt_s.stop_det = s_ff.scl_s & s_ff.scl_d & ~s_ff.sda_d & s_ff.sda_s;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
				scl_d: 1'b1, sda_d: 1'b1, start_det: 1'b0, stop_det: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign cond.scl = s_ff.scl_d;
	assign cond.sda = s_ff.sda_d;
	assign cond.start_det = s_ff.start_det;
	assign cond.stop_det = s_ff.stop_det;

endmodule

// File: rtl/ibf_top.sv
// I2C bus flag and control block with APB register access.
// Assumes a 20 MHz pclk, APB4 master, and raw scl/sda pin levels.
//
// Overview of operation
// - Reset clears the flag register to zero.
// - Byte or bit access; two flags read-only.
// - Option bits writable only while controller disabled.
// - Bits six and seven ignore all writes.
// - Failed start without reservation: clear trigger, flag.
// - Fail flag clears on trigger, disable, reset.
// - Busy sets on start, or enable without option.
// - Busy clears on stop, disable, reset.
// - Option chooses start after stop or immediately.
// - Initial-start bit set by software, cleared on start.
// - Reservation-disable: zero enables reservation, software only.
// - Enable with initial-start option leaves busy clear.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module ibf_top
	import ibf_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// I2C lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Controller side
	output logic start_gen,
	output logic bus_busy,
	// Interrupt
	output logic irq
);

	ibf_state_t s_ff;
	ibf_state_t nxt_s;
	ibf_cond_t cond;

	// ------------------------------------------------------------
	// Bus condition detector
	// ------------------------------------------------------------
	ibf_cond_det u_det (
		.pclk(pclk),
		.presetn(presetn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.cond(cond)
	);

	// ------------------------------------------------------------
	// Register read view
	// ------------------------------------------------------------
	function automatic logic [7:0] flag_view(input ibf_state_t st);
		logic [7:0] v;
		v = IBF_FLAG_RESET;
		v[IBF_FLAG_STCF] = st.start_fail_flag;
		v[IBF_FLAG_BSY] = st.bus_busy_flag;
		v[IBF_FLAG_ISE] = st.initial_start_enable;
		v[IBF_FLAG_RSV] = st.reservation_disable;
		return v;
	endfunction

	function automatic logic [3:0] line_view(input ibf_state_t st, input ibf_cond_t c);
		logic [3:0] v;
		v = 4'h0;
		v[IBF_LINE_PERMIT] = st.start_permit;
		v[IBF_LINE_SCL] = c.scl;
		v[IBF_LINE_SDA] = c.sda;
		v[IBF_LINE_PEND] = st.start_trigger;
		return v;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic acc_first;
		logic commit;
		logic wr_lane0;
		logic mapped;
		logic new_ena;
		logic [31:0] rd;
		logic [IBF_NUM_EV-1:0] ev;
		acc_first = 1'b0;
		commit = 1'b0;
		wr_lane0 = 1'b0;
		mapped = 1'b0;
		new_ena = 1'b0;
		rd = IBF_RDATA_RESET;
		ev = IBF_EV_RESET;
		nxt_s = s_ff;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		nxt_s.start_gen = 1'b0;

		// Address decode and read data, answered one cycle into the access.
		case (paddr)
			IBF_OFS_FLAG: begin
				mapped = 1'b1;
				rd = {24'h000000, flag_view(s_ff)};
			end
			IBF_OFS_CTRL: begin
				mapped = 1'b1;
				rd[IBF_CTRL_ENA] = s_ff.controller_enable;
				rd[IBF_CTRL_STT] = s_ff.start_trigger;
			end
			IBF_OFS_IRQ_STAT: begin
				mapped = 1'b1;
				rd[IBF_NUM_EV-1:0] = s_ff.irq_stat;
			end
			IBF_OFS_IRQ_CLR: begin
				mapped = 1'b1;
			end
			IBF_OFS_IRQ_ENA: begin
				mapped = 1'b1;
				rd[IBF_NUM_EV-1:0] = s_ff.irq_ena;
			end
			IBF_OFS_LINE: begin
				mapped = 1'b1;
				rd[3:0] = line_view(s_ff, cond);
			end
			default: begin
				mapped = 1'b0;
			end
		endcase

		acc_first = psel & penable & ~s_ff.pready;
		if (acc_first) begin
			nxt_s.pready = 1'b1;
			nxt_s.pslverr = ~mapped;
			nxt_s.prdata = pwrite ? IBF_RDATA_RESET : rd;
		end

		// Writes take effect on the edge that samples pready high.
		commit = psel & penable & s_ff.pready & pwrite & ~s_ff.pslverr;
		wr_lane0 = commit & pstrb[0];
		new_ena = s_ff.controller_enable;

		// ------------------------------------------------------------
		// Software writes
		// ------------------------------------------------------------
		if (wr_lane0) begin
			case (paddr)
				IBF_OFS_FLAG: begin
					// Status bits 7 and 6 are not writable.
					if (!s_ff.controller_enable) begin
						nxt_s.initial_start_enable = pwdata[IBF_FLAG_ISE];
						nxt_s.reservation_disable = pwdata[IBF_FLAG_RSV];
					end
				end
				IBF_OFS_CTRL: begin
					new_ena = pwdata[IBF_CTRL_ENA];
					nxt_s.controller_enable = new_ena;
					if (pwdata[IBF_CTRL_STT] && new_ena) begin
						nxt_s.start_trigger = 1'b1;
						nxt_s.start_fail_flag = 1'b0;
					end
				end
				IBF_OFS_IRQ_CLR: begin
					nxt_s.irq_stat = s_ff.irq_stat & ~pwdata[IBF_NUM_EV-1:0];
				end
				IBF_OFS_IRQ_ENA: begin
					nxt_s.irq_ena = pwdata[IBF_NUM_EV-1:0];
				end
				default: begin
					nxt_s.irq_ena = nxt_s.irq_ena;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Enable transitions
		// ------------------------------------------------------------
		if (s_ff.controller_enable && !new_ena) begin
			nxt_s.start_fail_flag = 1'b0;
			nxt_s.bus_busy_flag = 1'b0;
			nxt_s.start_permit = 1'b0;
			nxt_s.start_trigger = 1'b0;
		end
		if (!s_ff.controller_enable && new_ena) begin
			if (!s_ff.initial_start_enable) begin
				nxt_s.bus_busy_flag = 1'b1;
				nxt_s.start_permit = 1'b0;
			end else begin
				// Bus assumed released; software checks the bus first.
				nxt_s.bus_busy_flag = 1'b0;
				nxt_s.start_permit = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// Start request handling
		// ------------------------------------------------------------
		if (s_ff.controller_enable && new_ena && s_ff.start_trigger) begin
			if (s_ff.start_permit && !s_ff.bus_busy_flag) begin
				nxt_s.start_gen = 1'b1;
				nxt_s.start_trigger = 1'b0;
			end else if (s_ff.reservation_disable) begin
				nxt_s.start_trigger = 1'b0;
				nxt_s.start_fail_flag = 1'b1;
				ev[IBF_EV_FAIL] = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// Bus conditions, applied last so they win over clears
		// ------------------------------------------------------------
		if (cond.start_det) begin
			nxt_s.initial_start_enable = 1'b0;
			ev[IBF_EV_START] = 1'b1;
			if (new_ena) begin
				nxt_s.bus_busy_flag = 1'b1;
			end
		end
		if (cond.stop_det) begin
			ev[IBF_EV_STOP] = 1'b1;
			if (new_ena) begin
				nxt_s.bus_busy_flag = 1'b0;
				nxt_s.start_permit = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// Interrupt status, set wins over clear
		// ------------------------------------------------------------
		nxt_s.irq_stat = nxt_s.irq_stat | ev;
		nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_ena);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '{start_fail_flag: IBF_FLAG_RESET[IBF_FLAG_STCF],
				bus_busy_flag: IBF_FLAG_RESET[IBF_FLAG_BSY],
				initial_start_enable: IBF_FLAG_RESET[IBF_FLAG_ISE],
				reservation_disable: IBF_FLAG_RESET[IBF_FLAG_RSV],
				controller_enable: 1'b0,
				start_trigger: 1'b0,
				start_permit: 1'b0,
				start_gen: 1'b0,
				irq_stat: IBF_EV_RESET,
				irq_ena: IBF_EV_RESET,
				irq: 1'b0,
				pready: 1'b0,
				pslverr: 1'b0,
				prdata: IBF_RDATA_RESET};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign pready = s_ff.pready;
	assign prdata = s_ff.prdata;
	assign pslverr = s_ff.pslverr;
	assign start_gen = s_ff.start_gen;
	assign bus_busy = s_ff.bus_busy_flag;
	assign irq = s_ff.irq;

endmodule

// File: dv/ibf_top_asserts.sv
// Checker for the I2C bus flag block.
// Assumes it is bound onto ibf_top and sees only its ports.
`timescale 1ns/1ps
module ibf_top_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Lines and outputs
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic start_gen,
	input wire logic bus_busy,
	input wire logic irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rst; $rose(presetn) |-> !bus_busy && !irq && !start_gen; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer in access phase");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("answer longer than one cycle");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without answer");
	property p_hi; pready |-> prdata[31:8] == 24'h000000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits not zero");
	property p_gen; start_gen |-> !$past(bus_busy) ##1 !start_gen; endproperty
	a_gen: assert property (p_gen) else $error("start while bus busy");
	property p_stop; $rose(sda_in) && scl_in && bus_busy |-> ##[1:6] !bus_busy; endproperty
	a_stop: assert property (p_stop) else $error("busy kept after stop");
	property p_irq; $fell(irq) |-> ($past(pwrite) && $past(pready)) ||
		($past(pwrite, 2) && $past(pready, 2));
	endproperty
	a_irq: assert property (p_irq) else $error("irq fell without a write");
endmodule
bind ibf_top ibf_top_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.prdata, .pslverr, .scl_in, .sda_in, .start_gen, .bus_busy, .irq);

// File: dv/ibf_bus_model.sv
// Model of the other parties on the shared I2C bus.
// Assumes open-drain lines with pull-ups, so released lines read high.
`timescale 1ns/1ps
module ibf_bus_model (
	// Bus lines
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Start, then one 200 ns clock pulse; the clock stands still outside frames.
	// Callers start on a pclk edge, so every change lands 10 ns off an edge.
	task automatic start_cond();
		#210 sda = 1'b0;
		#200 scl = 1'b0;
		#200 scl = 1'b1;
		#200 scl = 1'b0;
	endtask
	// Stop: clock low, data low, clock high, then data rises while the clock is high.
	task automatic stop_cond();
		#210 scl = 1'b0;
		#200 sda = 1'b0;
		#200 scl = 1'b1;
		#200 sda = 1'b1;
	endtask
endmodule

// File: dv/ibf_top_tb.sv
// Self-checking bench for the I2C bus flag block.
// Assumes the APB answer of ibf_top and the bus model of ibf_bus_model.
`timescale 1ns/1ps
module ibf_top_tb
	import ibf_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, start_gen, bus_busy, irq, scl_in, sda_in, rerr;
	logic [31:0] prdata, rdat;
	logic [15:0] seed = 16'h0582;
	logic gen_seen = 1'b0;
	int fail_count = 0;
	int cmp_count = 0;
	// ----------------------------------------
	// Clock, design and bus model
	// ----------------------------------------
	always #25 pclk = ~pclk;
	always @(posedge pclk) if (start_gen === 1'b1) gen_seen <= 1'b1;
	ibf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
		.start_gen(start_gen), .bus_busy(bus_busy), .irq(irq));
	ibf_bus_model i_bm (.scl(scl_in), .sda(sda_in));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] flag_wr(input logic [7:0] d);
		return {24'h000000, d & 8'h03};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h00000000);
		chk(n, e, rdat);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("flag reset", IBF_OFS_FLAG, 32'h00000000);
		apb(8'h18, 1'b0, 32'h00000000);
		chk("unmapped error", 32'h00000001, {31'h0, rerr});
		repeat (4) begin
			seed = lfsr(seed);
			apb(IBF_OFS_FLAG, 1'b1, {16'h0000, seed});
			rd_chk("flag write", IBF_OFS_FLAG, flag_wr(seed[7:0]));
		end
		pstrb <= 4'hE;
		apb(IBF_OFS_FLAG, 1'b1, 32'h00000003);
		pstrb <= 4'hF;
		rd_chk("strobe off", IBF_OFS_FLAG, flag_wr(seed[7:0]));
		$display("test reset and access done");
		apb(IBF_OFS_FLAG, 1'b1, 32'h00000001);
		apb(IBF_OFS_CTRL, 1'b1, 32'h00000001);
		rd_chk("busy on enable", IBF_OFS_FLAG, 32'h00000041);
		apb(IBF_OFS_FLAG, 1'b1, 32'h00000002);
		rd_chk("locked flag", IBF_OFS_FLAG, 32'h00000041);
		apb(IBF_OFS_CTRL, 1'b1, 32'h00000003);
		rd_chk("start fail", IBF_OFS_FLAG, 32'h000000C1);
		chk("no start on fail", 32'h00000000, {31'h0, gen_seen});
		chk("irq masked", 32'h00000000, {31'h0, irq});
		apb(IBF_OFS_IRQ_ENA, 1'b1, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk("irq raised", 32'h00000001, {31'h0, irq});
		apb(IBF_OFS_IRQ_CLR, 1'b1, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'h00000000, {31'h0, irq});
		$display("test start fail done");
		i_bm.stop_cond();
		repeat (8) @(posedge pclk);
		rd_chk("busy stop", IBF_OFS_FLAG, 32'h00000081);
		apb(IBF_OFS_CTRL, 1'b1, 32'h00000003);
		rd_chk("fail cleared", IBF_OFS_FLAG, 32'h00000001);
		chk("start made", 32'h00000001, {31'h0, gen_seen});
		i_bm.start_cond();
		repeat (8) @(posedge pclk);
		rd_chk("busy start", IBF_OFS_FLAG, 32'h00000041);
		chk("busy pin", 32'h00000001, {31'h0, bus_busy});
		apb(IBF_OFS_CTRL, 1'b1, 32'h00000000);
		rd_chk("disable clears", IBF_OFS_FLAG, 32'h00000001);
		chk("busy pin clear", 32'h00000000, {31'h0, bus_busy});
		i_bm.stop_cond();
		$display("test busy done");
		apb(IBF_OFS_FLAG, 1'b1, 32'h00000002);
		rd_chk("bus idle", IBF_OFS_LINE, 32'h00000006);
		apb(IBF_OFS_CTRL, 1'b1, 32'h00000001);
		rd_chk("busy kept clear", IBF_OFS_FLAG, 32'h00000002);
		rd_chk("permit at once", IBF_OFS_LINE, 32'h00000007);
		i_bm.start_cond();
		repeat (8) @(posedge pclk);
		apb(IBF_OFS_FLAG, 1'b0, 32'h00000000);
		chk("initial start cleared", 32'h00000000, rdat & 32'h00000002);
		i_bm.stop_cond();
		repeat (8) @(posedge pclk);
		$display("test initial start done");
		rd_chk("event status", IBF_OFS_IRQ_STAT, 32'h00000006);
		apb(IBF_OFS_CTRL, 1'b1, 32'h00000000);
		apb(IBF_OFS_FLAG, 1'b1, 32'h00000003);
		rd_chk("flag set", IBF_OFS_FLAG, 32'h00000003);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("flag after reset", IBF_OFS_FLAG, 32'h00000000);
		rd_chk("control after reset", IBF_OFS_CTRL, 32'h00000000);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule
